//--- idc_axil_slave.sv
// axi4-lite slave holding control and showing status
// assumes: 32-bit data, one outstanding write and read
`timescale 1ns/1ps
`include "idc_defines.svh"
module idc_axil_slave import idc_pkg::*; (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // write channels
    input  wire logic [`IDC_AW-1:0] awaddr,
    input  wire logic             awvalid,
    output logic                  awready,
    input  wire logic [31:0]      wdata,
    input  wire logic [3:0]       wstrb,
    input  wire logic             wvalid,
    output logic                  wready,
    output logic [1:0]            bresp,
    output logic                  bvalid,
    input  wire logic             bready,
    // read channels
    input  wire logic [`IDC_AW-1:0] araddr,
    input  wire logic             arvalid,
    output logic                  arready,
    output logic [31:0]           rdata,
    output logic [1:0]            rresp,
    output logic                  rvalid,
    input  wire logic             rready,
    // register carrier
    idc_reg_if.slv                rif
);
    typedef struct packed {
        logic               aw_ok;
        logic [`IDC_AW-1:0] aw;
        logic               w_ok;
        logic [7:0]         wd;
        logic               wb0;
        logic               bv;
        logic [1:0]         br;
        logic               rv;
        logic [31:0]        rd;
        logic [1:0]         rr;
        logic [1:0]         ctrl;
    } idc_axs_t;

    idc_axs_t s_reg;
    idc_axs_t s_next;

    always_comb begin
        s_next = s_reg;
        if (awvalid && awready) begin
            s_next.aw_ok = 1'b1;
            s_next.aw    = awaddr;
        end
        if (wvalid && wready) begin
            s_next.w_ok = 1'b1;
            s_next.wd   = wdata[7:0];
            s_next.wb0  = wstrb[0];
        end
        if (s_reg.aw_ok && s_reg.w_ok) begin
            s_next.aw_ok = 1'b0;
            s_next.w_ok  = 1'b0;
            s_next.bv    = 1'b1;
            s_next.br    = 2'h0;
            case (s_reg.aw)
                `IDC_OFF_CTRL: begin
                    if (s_reg.wb0) begin
                        s_next.ctrl = s_reg.wd[1:0];
                    end
                end
                `IDC_OFF_STAT, `IDC_OFF_INSTR: begin
                    s_next.br = 2'h0;
                end
                default: begin
                    s_next.br = 2'h2;
                end
            endcase
        end
        if (s_reg.bv && bready) begin
            s_next.bv = 1'b0;
        end
        if (arvalid && arready) begin
            s_next.rv = 1'b1;
            s_next.rr = 2'h0;
            case (araddr)
                `IDC_OFF_CTRL:  s_next.rd = {30'h0, s_reg.ctrl};
                `IDC_OFF_STAT:  s_next.rd = rif.stat;
                `IDC_OFF_INSTR: s_next.rd = rif.instr;
                default: begin
                    s_next.rd = 32'h0;
                    s_next.rr = 2'h2;
                end
            endcase
        end else if (s_reg.rv && rready) begin
            s_next.rv = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg      <= '0;
            s_reg.ctrl <= `IDC_CTRL_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = !s_reg.aw_ok && !s_reg.bv;
    assign wready  = !s_reg.w_ok && !s_reg.bv;
    assign bvalid  = s_reg.bv;
    assign bresp   = s_reg.br;
    assign arready = !s_reg.rv;
    assign rvalid  = s_reg.rv;
    assign rdata   = s_reg.rd;
    assign rresp   = s_reg.rr;
    assign rif.run = s_reg.ctrl[`IDC_CTRL_RUN];
    assign rif.psa = s_reg.ctrl[`IDC_CTRL_PSA];
endmodule

//--- idc_decoder.sv
// 14-bit instruction decoder, top level
// assumes: instr_word and skip_cond come from logic on clk
`timescale 1ns/1ps
`include "idc_defines.svh"
module idc_decoder import idc_pkg::*; (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // register bus
    input  wire logic [`IDC_AW-1:0] awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    input  wire logic [`IDC_AW-1:0] araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // program memory and datapath
    input  wire logic [13:0]        instr_word,
    input  wire logic               skip_cond,
    // cycle timing
    output logic                    cycle_start,
    output logic                    cycle_end,
    output logic [1:0]              q_phase,
    output logic                    exec_valid,
    // decoded controls
    output logic [4:0]              alu_op,
    output logic                    wr_acc,
    output logic                    wr_file,
    output logic                    use_literal,
    output logic [4:0]              flag_mask,
    output logic                    two_cycle,
    output logic                    skip_op,
    output logic                    pc_load,
    output logic                    push_ret,
    output logic                    pop_ret,
    output logic                    gie_set,
    output logic                    enter_standby,
    output logic                    wdt_clear,
    output logic                    read_pins,
    output logic                    clr_prescaler,
    output logic [2:0]              bit_idx,
    output logic [6:0]              file_addr,
    output logic [10:0]             literal
);
    // ------------------------------------------------------------
    // sub blocks
    // ------------------------------------------------------------
    idc_reg_if rif ();

    idc_axil_slave u_bus (
        .clk     (clk),
        .rst_n   (rst_n),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif)
    );

    idc_phase_div u_ph (
        .clk       (clk),
        .rst_n     (rst_n),
        .en        (rif.run),
        .q         (q_phase),
        .cyc_start (cycle_start),
        .cyc_end   (cycle_end)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic idc_dec_t idc_decode(input logic [13:0] w, input logic psa);
        idc_dec_t d;
        logic     rmw;
        logic     n2;
        d         = '0;
        rmw       = 1'b0;
        n2        = 1'b0;
        d.faddr   = w[6:0];
        d.bitn    = w[9:7];
        d.k       = w[10:0];
        case (w[13:12])
            2'b00: begin
                d.wr_acc  = ~w[7];
                d.wr_file = w[7];
                rmw       = 1'b1;
                n2        = 1'b1;
                case (w[11:8])
                    4'h7: begin d.alu = ALU_ADD;  d.flags = `IDC_FL_CDZ; end
                    4'h2: begin d.alu = ALU_SUB;  d.flags = `IDC_FL_CDZ; end
                    4'h4: begin d.alu = ALU_OR;   d.flags = `IDC_FL_Z;   end
                    4'h5: begin d.alu = ALU_AND;  d.flags = `IDC_FL_Z;   end
                    4'h6: begin d.alu = ALU_XOR;  d.flags = `IDC_FL_Z;   end
                    4'hd: begin d.alu = ALU_RL;   d.flags = `IDC_FL_C;   end
                    4'hc: begin d.alu = ALU_RR;   d.flags = `IDC_FL_C;   end
                    4'he: d.alu = ALU_SWAP;
                    4'hb: begin d.alu = ALU_DEC;  d.skip = 1'b1;         end
                    4'h3: begin d.alu = ALU_DEC;  d.flags = `IDC_FL_Z;   end
                    4'hf: begin d.alu = ALU_INC;  d.skip = 1'b1;         end
                    4'ha: begin d.alu = ALU_INC;  d.flags = `IDC_FL_Z;   end
                    4'h9: begin d.alu = ALU_COM;  d.flags = `IDC_FL_Z;   end
                    4'h8: begin d.alu = ALU_COPY; d.flags = `IDC_FL_Z;   end
                    4'h1: begin
                        d.alu   = ALU_CLR;
                        d.flags = `IDC_FL_Z;
                        rmw     = 1'b0;
                        n2      = w[7];
                    end
                    4'h0: begin
                        rmw      = 1'b0;
                        n2       = 1'b0;
                        d.wr_acc = 1'b0;
                        if (w[7]) begin
                            d.alu = ALU_MOVW;
                        end else begin
                            d.wr_file = 1'b0;
                            case (w)
                                `IDC_W_RET: begin
                                    d.pop = 1'b1;
                                    d.two_cyc = 1'b1;
                                end
                                `IDC_W_RETI: begin
                                    d.pop = 1'b1;
                                    d.gie = 1'b1;
                                    d.two_cyc = 1'b1;
                                end
                                `IDC_W_SLEEP: begin d.sleep = 1'b1; d.flags = `IDC_FL_TOPD; end
                                `IDC_W_WDT:   begin d.wdt = 1'b1;   d.flags = `IDC_FL_TOPD; end
                                default: d.alu = ALU_NONE;
                            endcase
                        end
                    end
                    default: d.alu = ALU_NONE;
                endcase
            end
            2'b01: begin
                case (w[11:10])
                    2'b00: begin d.alu = ALU_BCLR; d.wr_file = 1'b1; end
                    2'b01: begin d.alu = ALU_BSET; d.wr_file = 1'b1; end
                    default: begin d.alu = ALU_BTEST; d.skip = 1'b1; end
                endcase
                rmw = ~w[11];
                n2  = ~w[11];
            end
            2'b10: begin
                d.pc_load = 1'b1;
                d.two_cyc = 1'b1;
                d.push    = ~w[11];
            end
            default: begin
                d.use_lit = 1'b1;
                d.wr_acc  = 1'b1;
                d.alu     = ALU_LIT;
                casez (w[11:8])
                    4'b00??: d.alu = ALU_LIT;
                    4'b01??: begin d.pop = 1'b1; d.two_cyc = 1'b1; end
                    4'h8: begin d.alu = ALU_OR;  d.flags = `IDC_FL_Z; end
                    4'h9: begin d.alu = ALU_AND; d.flags = `IDC_FL_Z; end
                    4'ha: begin d.alu = ALU_XOR; d.flags = `IDC_FL_Z; end
                    4'b110?: begin d.alu = ALU_SUB; d.flags = `IDC_FL_CDZ; end
                    4'b111?: begin d.alu = ALU_ADD; d.flags = `IDC_FL_CDZ; end
                    default: begin d.alu = ALU_NONE; d.wr_acc = 1'b0; end
                endcase
            end
        endcase
        d.rd_pins = rmw && (d.faddr == `IDC_FA_FIRST_PORT || d.faddr == `IDC_FA_SECOND_PORT);
        d.psc_clr = psa && n2 && d.wr_file && (d.faddr == `IDC_FA_TIMER_ZERO);
        return d;
    endfunction

    // ------------------------------------------------------------
    // cycle sequencing
    // ------------------------------------------------------------
    typedef struct packed {
        logic [13:0] instr;
        idc_dec_t    dec;
        logic        exec;
        logic        flush;
    } idc_core_t;

    idc_core_t s_reg;
    idc_core_t s_next;

    always_comb begin
        s_next = s_reg;
        if (cycle_start) begin
            s_next.exec  = ~s_reg.flush;
            s_next.flush = 1'b0;
            s_next.instr = s_reg.flush ? `IDC_W_NOP : instr_word;
            s_next.dec   = s_reg.flush ? '0 : idc_decode(instr_word, rif.psa);
        end
        if (cycle_end) begin
            s_next.flush = s_reg.exec && (s_reg.dec.two_cyc || (s_reg.dec.skip && skip_cond));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs and status
    // ------------------------------------------------------------
    assign exec_valid    = s_reg.exec;
    assign alu_op        = s_reg.dec.alu;
    assign wr_acc        = s_reg.dec.wr_acc;
    assign wr_file       = s_reg.dec.wr_file;
    assign use_literal   = s_reg.dec.use_lit;
    assign flag_mask     = s_reg.dec.flags;
    assign two_cycle     = s_reg.dec.two_cyc;
    assign skip_op       = s_reg.dec.skip;
    assign pc_load       = s_reg.dec.pc_load;
    assign push_ret      = s_reg.dec.push;
    assign pop_ret       = s_reg.dec.pop;
    assign gie_set       = s_reg.dec.gie;
    assign enter_standby = s_reg.dec.sleep;
    assign wdt_clear     = s_reg.dec.wdt;
    assign read_pins     = s_reg.dec.rd_pins;
    assign clr_prescaler = s_reg.dec.psc_clr;
    assign bit_idx       = s_reg.dec.bitn;
    assign file_addr     = s_reg.dec.faddr;
    assign literal       = s_reg.dec.k;
    assign rif.instr     = {18'h0, s_reg.instr};
    assign rif.stat      = {18'h0, s_reg.flush, s_reg.exec, s_reg.dec.two_cyc,
                            s_reg.dec.wr_file, s_reg.dec.alu, s_reg.dec.flags};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire byte_op = exec_valid && s_reg.instr[13:12] == 2'b00 && s_reg.instr[11:8] != 4'h0;

    cycle_len_a: assert property (cycle_start ##1 rif.run [*4] |-> cycle_start)
        else $error("instruction cycle not four clocks");
    dest_sel_a: assert property (byte_op |-> wr_file == s_reg.instr[7] && wr_acc != s_reg.instr[7])
        else $error("destination select wrong");
    add_flags_a: assert property (exec_valid && s_reg.instr[13:9] == 5'h1f |-> flag_mask == 5'h07)
        else $error("add literal flags wrong");
    sub_one_a: assert property (exec_valid && s_reg.instr[13:8] == 6'h02 |-> !two_cycle && flag_mask == 5'h07)
        else $error("subtract decode wrong");
    logic_z_a: assert property (byte_op && s_reg.instr[11:8] inside {4'h4, 4'h5, 4'h6} |-> flag_mask == 5'h04)
        else $error("logic op flags wrong");
    rot_left_a: assert property (exec_valid && s_reg.instr[13:8] == 6'h0d
        |-> alu_op == ALU_RL && flag_mask == 5'h01)
        else $error("rotate left decode wrong");
    swap_none_a: assert property (exec_valid && s_reg.instr[13:8] == 6'h0e |-> flag_mask == 5'h00)
        else $error("nibble exchange touched flags");
    bit_flags_a: assert property (exec_valid && s_reg.instr[13:12] == 2'b01 |-> flag_mask == 5'h00)
        else $error("bit op touched flags");
    skip_nop_a: assert property (cycle_end && exec_valid && skip_op && skip_cond |-> ##2 !exec_valid)
        else $error("true skip not followed by nop");
    two_cyc_a: assert property (cycle_end && exec_valid && two_cycle |-> ##2 !exec_valid ##4 1'b1)
        else $error("two-cycle op not followed by nop");
    standby_a: assert property (exec_valid && s_reg.instr == 14'h0063
        |-> enter_standby && flag_mask == 5'h18)
        else $error("standby decode wrong");
    psc_clr_a: assert property (clr_prescaler |-> rif.psa && file_addr == 7'h01 && wr_file)
        else $error("prescaler clear without timer write");
    pins_a: assert property (read_pins |-> exec_valid && file_addr inside {7'h05, 7'h06})
        else $error("pin read on wrong address");
    jump_a: assert property (exec_valid && s_reg.instr[13:12] == 2'b10 |-> pc_load && two_cycle)
        else $error("call or jump decode wrong");
    lit_z_a: assert property (exec_valid && s_reg.instr[13:9] == 5'h1c |-> wr_acc && flag_mask == 5'h04)
        else $error("or or and literal decode wrong");
    ret_k_a: assert property (exec_valid && s_reg.instr[13:10] == 4'hd |-> pop_ret && two_cycle && wr_acc)
        else $error("return with constant decode wrong");
    skip_dec_a: assert property (exec_valid && s_reg.instr[13:8] inside {6'h0b, 6'h0f}
        |-> skip_op && flag_mask == 5'h00)
        else $error("skip on zero decode wrong");
    bit_skip_a: assert property (exec_valid && s_reg.instr[13:11] == 3'h3 |-> skip_op && !wr_file)
        else $error("bit test decode wrong");
    nop_zero_a: assert property (exec_valid && s_reg.instr == 14'h0000
        |-> alu_op == ALU_NONE && !wr_acc && !wr_file)
        else $error("zero word not a no-operation");

    skip_cv: cover property (cycle_end && exec_valid && skip_op && skip_cond ##2 !exec_valid);
    call_cv: cover property (exec_valid && push_ret);
    psc_cv:  cover property (clr_prescaler);
    ret_cv:  cover property (exec_valid && pop_ret ##4 !exec_valid);
    pins_cv: cover property (read_pins);
endmodule

//--- idc_defines.svh
// constants of the 14-bit instruction decoder
// assumes: included by the bus slave, decoder and phase divider modules
//
// Contract
// - d bit 0 to accumulator, 1 to file
// - instruction cycle is four oscillator periods
// - add literal and add to file: C,DC,Z
// - subtract forms, one cycle, C,DC,Z
// - or, and, xor with file: Z only
// - rotate left through carry, C only
// - rotate right C only; nibble exchange none
// - decrement skip none; decrement Z
// - increment skip none; increment Z
// - bit clear, set, test skip if low
// - test skip if high; bit ops no flags
// - or and and literal to accumulator, Z
// - return with constant two cycles; load one
// - return and interrupt return two cycles
// - standby and watchdog kick touch TO,PD
// - io read-modify-write reads pin levels
// - timer count write clears assigned prescaler; the move-to-file form (ALU_MOVW) does not clear it
// - taken branch or skip adds NOP cycle
`ifndef IDC_DEFINES_SVH
`define IDC_DEFINES_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define IDC_AW          4
`define IDC_OFF_CTRL    4'h0
`define IDC_OFF_STAT    4'h4
`define IDC_OFF_INSTR   4'h8
`define IDC_CTRL_RUN    0
`define IDC_CTRL_PSA    1
`define IDC_CTRL_RST    2'h1

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IDC_OSC_PER_CYC 4
`define IDC_Q_LAST      2'h3

// ------------------------------------------------------------
// flag mask bits and file addresses
// ------------------------------------------------------------
`define IDC_FL_C        5'h01
`define IDC_FL_DC       5'h02
`define IDC_FL_Z        5'h04
`define IDC_FL_TOPD     5'h18
`define IDC_FL_CDZ      5'h07
`define IDC_FA_TIMER_ZERO  7'h01
`define IDC_FA_FIRST_PORT  7'h05
`define IDC_FA_SECOND_PORT 7'h06

// ------------------------------------------------------------
// fixed words of the control group
// ------------------------------------------------------------
`define IDC_W_RET       14'h0008
`define IDC_W_RETI      14'h0009
`define IDC_W_SLEEP     14'h0063
`define IDC_W_WDT       14'h0064
`define IDC_W_NOP       14'h0000

`endif

//--- idc_phase_div.sv
// divides clk into four-period instruction cycles
// assumes: en from same clock domain
`timescale 1ns/1ps
`include "idc_defines.svh"
module idc_phase_div import idc_pkg::*; (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       en,
    // phase
    output logic [1:0] q,
    output logic       cyc_start,
    output logic       cyc_end
);
    typedef struct packed {
        logic [1:0] q;
    } idc_ph_t;

    idc_ph_t s_reg;
    idc_ph_t s_next;

    always_comb begin
        s_next = s_reg;
        if (en) begin
            s_next.q = s_reg.q + 2'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign q         = s_reg.q;
    assign cyc_start = en && (s_reg.q == 2'h0);
    assign cyc_end   = en && (s_reg.q == `IDC_Q_LAST);
endmodule

//--- idc_pkg.sv
// types of the instruction decoder
// assumes: nothing
package idc_pkg;

    typedef enum logic [4:0] {
        ALU_NONE, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR,
        ALU_CLR, ALU_COM, ALU_DEC, ALU_INC, ALU_COPY, ALU_MOVW,
        ALU_RL, ALU_RR, ALU_SWAP, ALU_BCLR, ALU_BSET, ALU_BTEST, ALU_LIT
    } idc_alu_t;

    typedef struct packed {
        idc_alu_t    alu;
        logic        wr_acc;
        logic        wr_file;
        logic        use_lit;
        logic [4:0]  flags;
        logic        two_cyc;
        logic        skip;
        logic        pc_load;
        logic        push;
        logic        pop;
        logic        gie;
        logic        sleep;
        logic        wdt;
        logic        rd_pins;
        logic        psc_clr;
        logic [2:0]  bitn;
        logic [6:0]  faddr;
        logic [10:0] k;
    } idc_dec_t;

endpackage

//--- idc_prog_mem.sv
// program memory model handing instruction words to the decoder
// assumes: one word per cycle_start edge, hold resets the fetch address to 0
`timescale 1ns/1ps
module idc_prog_mem (
    // clock and control
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hold,
    input  wire logic        cycle_start,
    // fetch
    output logic      [13:0] instr_word
);
    logic [13:0] mem [64];
    logic [5:0]  pc_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            pc_reg <= 6'h00;
        else if (hold)
            pc_reg <= 6'h00;
        else if (cycle_start)
            pc_reg <= pc_reg + 6'h01;
    end
    assign instr_word = mem[pc_reg];
endmodule

//--- idc_reg_if.sv
// register carrier between bus slave and decoder core
// assumes: one clock domain
`timescale 1ns/1ps
interface idc_reg_if;
    logic        run;
    logic        psa;
    logic [31:0] stat;
    logic [31:0] instr;
    modport slv  (output run, psa, input stat, instr);
    modport core (input run, psa, output stat, instr);
endinterface

//--- tb_mcu_14bit_instruction_decoder.sv
// self-checking bench: bus tasks, then a program checked word by word
// assumes: decoder outputs stand four clocks after each fetch
`timescale 1ns/1ps
module tb_mcu_14bit_instruction_decoder import idc_pkg::*;;
    typedef struct packed {
        logic [13:0] w;
        logic [4:0]  a;
        logic [4:0]  f;
        logic        t;
        logic        e;
        logic        s;
        logic [3:0]  x;
    } idc_tb_ent_t;
    localparam int N = 38;
    // word, alu, flags, two-cycle, executes, skip taken, acc/file/prescaler/pins
    idc_tb_ent_t prog [N] = '{
        '{'h3e15,1,7,0,1,0,8}, '{'h07a0,1,7,0,1,0,4}, '{'h3c05,2,7,0,1,0,8}, '{'h0220,2,7,0,1,0,8},
        '{'h0420,4,4,0,1,0,8}, '{'h05a0,3,4,0,1,0,4}, '{'h0620,5,4,0,1,0,8}, '{'h0da0,12,1,0,1,0,4},
        '{'h0ca0,13,1,0,1,0,4}, '{'h0ea0,14,0,0,1,0,4}, '{'h03a0,8,4,0,1,0,4}, '{'h0aa0,9,4,0,1,0,4},
        '{'h3855,4,4,0,1,0,8}, '{'h3955,3,4,0,1,0,8}, '{'h1020,15,0,0,1,0,4}, '{'h1420,16,0,0,1,0,4},
        '{'h3000,18,0,0,1,0,8}, '{'h0064,0,24,0,1,0,0}, '{'h0063,0,24,0,1,0,0}, '{'h3455,18,0,1,1,0,8},
        '{0,0,0,0,0,0,0}, '{'h0008,0,0,1,1,0,0}, '{0,0,0,0,0,0,0}, '{'h0009,0,0,1,1,0,0},
        '{0,0,0,0,0,0,0}, '{'h2005,0,0,1,1,0,0}, '{0,0,0,0,0,0,0}, '{'h2805,0,0,1,1,0,0},
        '{0,0,0,0,0,0,0}, '{'h0ba0,8,0,0,1,1,4}, '{0,0,0,0,0,0,0}, '{'h0fa0,9,0,0,1,0,4},
        '{'h1820,17,0,0,1,0,0}, '{'h1c20,17,0,0,1,1,0}, '{0,0,0,0,0,0,0}, '{'h0a81,9,4,0,1,0,6},
        '{'h0886,10,4,0,1,0,5}, '{0,0,0,0,1,0,0}};
    logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic skip_cond, cycle_start, cycle_end, exec_valid, wr_acc, wr_file, use_literal, two_cycle, skip_op;
    logic pc_load, push_ret, pop_ret, gie_set, enter_standby, wdt_clear, read_pins, clr_prescaler, hold;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp, q_phase;
    logic [4:0]  alu_op, flag_mask;
    logic [13:0] instr_word, w;
    logic [2:0]  bit_idx;
    logic [6:0]  file_addr;
    logic [10:0] literal;
    int err_total, n_compared, idx;
    idc_decoder u_dut (.*);
    idc_prog_mem u_mem (.clk, .rst_n, .hold, .cycle_start, .instr_word);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s step %0d expected %h seen %h", nm, idx, exp, seen);
        end
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, bd;
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid && awready; tw = wvalid && wready; bd = bvalid;
            if (bd) chk("bresp", 32'(bresp), 32'(r));
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!bd);
        bready <= 1'b0;
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ta, bd;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid && arready; bd = rvalid;
            if (bd) chk("rdata rresp", {rdata[29:0], rresp}, {e[29:0], r});
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end while (!bd);
        rready <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, skip_cond, awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        hold = 1'b1;
        #1 for (int i = 0; i < 64; i++) u_mem.mem[i] = (i < N) ? prog[i].w : 14'h0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        axr(4'h0, 32'h1, 2'h0);
        axw(4'h0, 32'h3, 2'h0);
        axr(4'h0, 32'h3, 2'h0);
        axw(4'hc, 32'h3, 2'h2);
        axr(4'hc, 32'h0, 2'h2);
        do @(negedge clk); while (cycle_start !== 1'b1);
        @(posedge clk);
        hold <= 1'b0;
        for (idx = 0; idx < N; idx++) begin
            do @(negedge clk); while (cycle_start !== 1'b1);
            @(posedge clk);
            skip_cond <= prog[idx].s;
            repeat (2) @(negedge clk);
            w = prog[idx].w;
            chk("alu", 32'(alu_op), 32'(prog[idx].a));
            chk("flags", 32'(flag_mask), 32'(prog[idx].f));
            chk("dest", 32'({wr_acc, wr_file, clr_prescaler, read_pins}), 32'(prog[idx].x));
            chk("two cycle", 32'(two_cycle), 32'(prog[idx].t));
            chk("exec phase", 32'({exec_valid, q_phase}), 32'({prog[idx].e, 2'h2}));
            chk("fields", 32'({literal, file_addr, bit_idx}), 32'({w[10:0], w[6:0], w[9:7]}));
            chk("branch", 32'({pc_load, push_ret, pop_ret, gie_set}), 32'({w[13:12] == 2'h2, w[13:11] == 3'h4,
                w inside {14'h8, 14'h9} || w[13:10] == 4'hd, w == 14'h9}));
            chk("misc", 32'({enter_standby, wdt_clear, use_literal, skip_op}), 32'({w == 14'h63, w == 14'h64,
                w[13:12] == 2'h3, w[13:11] == 3'h3 || w[13:8] inside {6'hb, 6'hf}}));
        end
        give_verdict();
    end
    initial begin
        #20000;
        err_total++;
        give_verdict();
    end
endmodule
